// ### rtl/drct_pkg.sv
// Package of offsets, field positions and reset values for the dual countdown timers.
package drct_pkg;
    // ------------------------------------------------------------------
    // Port addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_GEN_CTRL = 8'h38;
    localparam logic [7:0] ADDR_IRQ_FLAG = 8'h39;
    localparam logic [7:0] ADDR_A_PERIOD = 8'h3A;
    localparam logic [7:0] ADDR_A_COUNT = 8'h3B;
    localparam logic [7:0] ADDR_B_PERIOD = 8'h3E;
    localparam logic [7:0] ADDR_B_COUNT = 8'h3F;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_A_SRC = 8;
    localparam int BIT_B_SRC = 9;
    localparam int BIT_A_RUN = 10;
    localparam int BIT_B_RUN = 11;
    localparam int BIT_A_FLAG = 1;
    localparam int BIT_B_FLAG = 2;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_TIMER = 16'h0000;
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [7:0] RST_FLAG = 8'h00;
endpackage

// ### rtl/drct_timers.sv
// Two auto-reload 16-bit countdown timers behind port-addressed registers.
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module drct_timers
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Reference oscillator from outside the clock domain
    input wire logic i_ref_osc,
    // Port-addressed register access
    input wire logic [7:0] i_port_addr,
    input wire logic i_port_wr,
    input wire logic i_port_rd,
    input wire logic [15:0] i_port_wdata,
    output logic [15:0] o_port_rdata,
    // Interrupt events and control bits for the interrupt controller
    output logic o_counter_a_irq_level,
    output logic o_counter_b_irq_level,
    output logic [7:0] o_irq_flags,
    output logic [15:0] o_gen_ctrl
);
    typedef struct packed {
        logic [1:0][15:0] period;
        logic [1:0][15:0] count;
        logic [15:0] ctrl;
        logic [7:0] flags;
        logic [1:0] half;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic [1:0] irq;
        logic [15:0] rdata;
    } drct_state_t;

    drct_state_t s_q;
    drct_state_t s_d;
    logic [1:0] tick;
    logic [1:0] under;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // One comb process; the flag write comes first so underflow sets win over clears.
    always_comb
    begin
        s_d = s_q;
        s_d.osc_s1 = i_ref_osc;
        s_d.osc_s2 = s_q.osc_s1;
        s_d.osc_s3 = s_q.osc_s2;
        tick = '0;
        under = '0;
        if (i_port_wr && i_port_addr == drct_pkg::ADDR_GEN_CTRL)
        begin
            s_d.ctrl = i_port_wdata;
        end
        if (i_port_wr && i_port_addr == drct_pkg::ADDR_IRQ_FLAG)
        begin
            s_d.flags = i_port_wdata[7:0];
        end
        for (int i = 0; i < 2; i++)
        begin
            s_d.half[i] = ~s_q.half[i];
            // Half master clock ticks on alternate cycles; the reference on a rising edge.
            if (s_q.ctrl[drct_pkg::BIT_A_SRC + i])
                tick[i] = s_q.osc_s2 & ~s_q.osc_s3;
            else
                tick[i] = s_q.half[i];
            if (s_q.ctrl[drct_pkg::BIT_A_RUN + i] && tick[i])
            begin
                if (s_q.count[i] == 16'h0000)
                begin
                    s_d.count[i] = s_q.period[i];
                    under[i] = 1'b1;
                end
                else
                    s_d.count[i] = s_q.count[i] - 16'h0001;
            end
        end
        if (i_port_wr && i_port_addr == drct_pkg::ADDR_A_PERIOD)
            s_d.period[0] = i_port_wdata;
        if (i_port_wr && i_port_addr == drct_pkg::ADDR_B_PERIOD)
            s_d.period[1] = i_port_wdata;
        // Count writes are last so they override a coincident reload.
        if (i_port_wr && i_port_addr == drct_pkg::ADDR_A_COUNT)
        begin
            s_d.count[0] = i_port_wdata;
            s_d.period[0] = i_port_wdata;
        end
        if (i_port_wr && i_port_addr == drct_pkg::ADDR_B_COUNT)
        begin
            s_d.count[1] = i_port_wdata;
            s_d.period[1] = i_port_wdata;
        end
        if (under[0])
            s_d.flags[drct_pkg::BIT_A_FLAG] = 1'b1;
        if (under[1])
            s_d.flags[drct_pkg::BIT_B_FLAG] = 1'b1;
        s_d.irq = under;
        // Read data is registered: it appears one cycle after the read strobe.
        case (i_port_addr)
            drct_pkg::ADDR_GEN_CTRL: s_d.rdata = s_q.ctrl;
            drct_pkg::ADDR_IRQ_FLAG: s_d.rdata = {8'h00, s_q.flags};
            drct_pkg::ADDR_A_PERIOD: s_d.rdata = s_q.period[0];
            drct_pkg::ADDR_A_COUNT: s_d.rdata = s_q.count[0];
            drct_pkg::ADDR_B_PERIOD: s_d.rdata = s_q.period[1];
            drct_pkg::ADDR_B_COUNT: s_d.rdata = s_q.count[1];
            default: s_d.rdata = 16'h0000;
        endcase
        if (!i_port_rd)
            s_d.rdata = s_q.rdata;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Flags are cleared here too; keeping them across reset is left to the system.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            s_q <= '0;
            s_q.period <= {drct_pkg::RST_TIMER, drct_pkg::RST_TIMER};
            s_q.count <= {drct_pkg::RST_TIMER, drct_pkg::RST_TIMER};
            s_q.ctrl <= drct_pkg::RST_CTRL;
            s_q.flags <= drct_pkg::RST_FLAG;
        end
        else
            s_q <= s_d;
    end

    assign o_port_rdata = s_q.rdata;
    assign o_counter_a_irq_level = s_q.irq[0];
    assign o_counter_b_irq_level = s_q.irq[1];
    assign o_irq_flags = s_q.flags;
    assign o_gen_ctrl = s_q.ctrl;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    chk_reload_period: assert property (
        (s_q.ctrl[drct_pkg::BIT_A_RUN] && tick[0] && s_q.count[0] == 16'h0000 && !i_port_wr)
        |=> s_q.count[0] == $past(s_q.period[0])) else $error("reload wrong");
    chk_irq_pulse: assert property (
        o_counter_a_irq_level |-> $past(s_q.count[0]) == 16'h0000) else $error("bad irq");
    chk_flag_set: assert property (
        under[1] |=> s_q.flags[drct_pkg::BIT_B_FLAG]) else $error("flag not set");
    chk_count_write: assert property (
        (i_port_wr && i_port_addr == drct_pkg::ADDR_B_COUNT)
        |=> s_q.count[1] == $past(i_port_wdata) && s_q.period[1] == $past(i_port_wdata))
        else $error("count write lost");
    chk_period_write: assert property (
        (i_port_wr && i_port_addr == drct_pkg::ADDR_A_PERIOD && !tick[0])
        |=> $stable(s_q.count[0])) else $error("period write moved count");
    chk_hold_stop: assert property (
        (!s_q.ctrl[drct_pkg::BIT_B_RUN] && !i_port_wr) |=> $stable(s_q.count[1]))
        else $error("stopped counter moved");
    chk_decrement: assert property (
        (s_q.ctrl[drct_pkg::BIT_A_RUN] && tick[0] && s_q.count[0] != 16'h0000 && !i_port_wr)
        |=> s_q.count[0] == $past(s_q.count[0]) - 16'h0001) else $error("bad decrement");
    chk_half_rate: assert property (
        (!s_q.ctrl[drct_pkg::BIT_A_SRC] && tick[0]) |=> !tick[0] || s_q.ctrl[drct_pkg::BIT_A_SRC])
        else $error("half clock ticks too fast");
    chk_read_live: assert property (
        (i_port_rd && i_port_addr == drct_pkg::ADDR_A_COUNT)
        |=> o_port_rdata == $past(s_q.count[0])) else $error("read not live");

    // Reset checks must see the reset cycle itself, so they opt out of the default disable.
    chk_reset_clear: assert property (@(posedge i_ref_clk) disable iff (1'b0)
        !i_rst_n |=> s_q.count == '0 && s_q.period == '0 && s_q.ctrl == '0)
        else $error("reset left state");
    // The underflow event of counter b follows the same zero count as counter a.
    chk_irq_b_pulse: assert property (
        o_counter_b_irq_level |-> $past(s_q.count[1]) == 16'h0000)
        else $error("bad irq b");
    // Each underflow leaves its own flag set even when software clears it that cycle.
    chk_flag_a_set: assert property (
        under[0] |=> s_q.flags[drct_pkg::BIT_A_FLAG]) else $error("flag a not set");
    // A count write in the reload cycle must win, or software loses its new start value.
    chk_write_beats_reload: assert property (
        (s_q.ctrl[drct_pkg::BIT_A_RUN] && tick[0] && s_q.count[0] == 16'h0000
            && i_port_wr && i_port_addr == drct_pkg::ADDR_A_COUNT)
        |=> s_q.count[0] == $past(i_port_wdata)) else $error("reload beat count write");
    // One reference edge may yield only one tick, however long the pin stays high.
    chk_osc_one_tick: assert property (
        (s_q.ctrl[drct_pkg::BIT_B_SRC] && tick[1])
        |=> !tick[1] || !s_q.ctrl[drct_pkg::BIT_B_SRC]) else $error("reference edge ticked twice");
    // Read data stands between reads so a slow reader still sees its value.
    chk_rdata_hold: assert property (
        !i_port_rd |=> $stable(o_port_rdata)) else $error("read data moved");
    chk_hold_stop_a: assert property (
        (!s_q.ctrl[drct_pkg::BIT_A_RUN] && !i_port_wr) |=> $stable(s_q.count[0]))
        else $error("stopped counter a moved");

    // Covers show both underflows, a reference tick, a reload-cycle write and a frozen count.
    cov_underflow_a: cover property (o_counter_a_irq_level);
    cov_underflow_b: cover property (o_counter_b_irq_level);
    cov_osc_tick: cover property (s_q.ctrl[drct_pkg::BIT_B_SRC] && tick[1]);
    cov_reload_write: cover property (s_q.count[0] == 16'h0000 && tick[0]
        && i_port_wr && i_port_addr == drct_pkg::ADDR_A_COUNT);
    cov_freeze: cover property (!s_q.ctrl[drct_pkg::BIT_A_RUN] && s_q.count[0] != 16'h0000);
endmodule // drct_timers

// ### verification/tb_top.sv
// Self-checking testbench for the dual countdown timers.
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------------------------------
    // Stimulus, observed outputs and counters
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic irq_a;
    logic irq_b;
    logic [7:0] flags;
    logic [15:0] ctrl;
    logic [15:0] v;
    logic [15:0] v2;
    logic [7:0] ra [6] = '{drct_pkg::ADDR_GEN_CTRL, drct_pkg::ADDR_IRQ_FLAG,
        drct_pkg::ADDR_A_PERIOD, drct_pkg::ADDR_A_COUNT, drct_pkg::ADDR_B_PERIOD,
        drct_pkg::ADDR_B_COUNT};
    int bad_count = 0;
    int n_checks = 0;
    int g;
    int n;

    drct_timers DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ref_osc(osc), .i_port_addr(addr),
        .i_port_wr(wr_en), .i_port_rd(rd_en), .i_port_wdata(wdata), .o_port_rdata(rdata),
        .o_counter_a_irq_level(irq_a), .o_counter_b_irq_level(irq_b), .o_irq_flags(flags),
        .o_gen_ctrl(ctrl));

    // The 10 MHz master clock.
    initial
    begin
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Port access and checking tasks
    // ------------------------------------------------------------------
    function automatic logic [7:0] cnt(input int x);
        return x ? drct_pkg::ADDR_B_COUNT : drct_pkg::ADDR_A_COUNT;
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
            bad_count++;
        end
    endtask

    // Strobes change at the falling edge so the rising edge samples settled values.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        d = rdata;
    endtask

    // Cycles between two underflow pulses; the bound keeps a dead counter from hanging.
    task automatic gap(input int x, output int c);
        int k;
        k = 0;
        c = 0;
        while ((x ? irq_b : irq_a) !== 1'b1 && k < 3000)
        begin
            @(negedge clk);
            k++;
        end
        do
        begin
            @(negedge clk);
            c++;
        end
        while ((x ? irq_b : irq_a) !== 1'b1 && c < 3000);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog sized well beyond the few hundred cycles the tests need.
    initial
    begin
        #(100 * 20000);
        bad_count++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(97345));
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        foreach (ra[i])
        begin
            rd(ra[i], v);
            chk("reset", 16'h0000, v);
        end
        for (int x = 0; x < 2; x++)
        begin
            v2 = 16'($urandom);
            wr(cnt(x) - 8'h01, v2);
            rd(cnt(x) - 8'h01, v);
            chk("period", v2, v);
            v2 = 16'($urandom_range(60000, 100));
            wr(cnt(x), v2);
            repeat (20) @(negedge clk);
            rd(cnt(x) - 8'h01, v);
            chk("period_copy", v2, v);
            rd(cnt(x), v);
            chk("idle_count", v2, v);
        end
        // Short random periods on each counter, measured between underflows.
        for (int x = 0; x < 2; x++)
        begin
            n = $urandom_range(9, 2);
            wr(cnt(x), 16'(n));
            wr(drct_pkg::ADDR_GEN_CTRL, 16'h0400 << x);
            chk("ctrl", 16'h0400 << x, ctrl);
            gap(x, g);
            chk("gap", 16'(2 * (n + 1)), 16'(g));
            chk("flag", 16'(2 << x), {8'h00, flags} & 16'(2 << x));
            wr(drct_pkg::ADDR_GEN_CTRL, 16'h0000);
            wr(drct_pkg::ADDR_IRQ_FLAG, 16'h0000);
        end
        // A period write mid-count waits for the reload.
        wr(drct_pkg::ADDR_A_COUNT, 16'h0014);
        wr(drct_pkg::ADDR_GEN_CTRL, 16'h0400);
        wr(drct_pkg::ADDR_A_PERIOD, 16'h0003);
        rd(drct_pkg::ADDR_A_COUNT, v);
        chk("count_kept", 16'h0001, {15'h0000, v > 16'h0003});
        gap(0, g);
        chk("new_gap", 16'h0008, 16'(g));
        // Freeze and resume without reload.
        wr(drct_pkg::ADDR_A_COUNT, 16'h03E8);
        repeat (20) @(negedge clk);
        wr(drct_pkg::ADDR_GEN_CTRL, 16'h0000);
        rd(drct_pkg::ADDR_A_COUNT, v);
        repeat (10) @(negedge clk);
        rd(drct_pkg::ADDR_A_COUNT, v2);
        chk("frozen", v, v2);
        wr(drct_pkg::ADDR_GEN_CTRL, 16'h0400);
        repeat (20) @(negedge clk);
        wr(drct_pkg::ADDR_GEN_CTRL, 16'h0000);
        rd(drct_pkg::ADDR_A_COUNT, v2);
        chk("resumed", 16'h0001, {15'h0000, v2 < v && v2 > v - 16'h001E});
        // Counter b on the reference oscillator: ten slow edges, ten decrements.
        // Started in the recommended order: source, run clear, count, unmask, run.
        wr(drct_pkg::ADDR_GEN_CTRL, 16'h0200);
        wr(drct_pkg::ADDR_B_COUNT, 16'h0032);
        wr(drct_pkg::ADDR_GEN_CTRL, 16'h0204);
        wr(drct_pkg::ADDR_GEN_CTRL, 16'h0A04);
        chk("ctrl_b", 16'h0A04, ctrl);
        repeat (10)
        begin
            osc = 1'b1;
            repeat (4) @(negedge clk);
            osc = 1'b0;
            repeat (4) @(negedge clk);
        end
        wr(drct_pkg::ADDR_GEN_CTRL, 16'h0204);
        rd(drct_pkg::ADDR_B_COUNT, v);
        chk("osc_count", 16'h0028, v);
        conclude();
    end
endmodule // tb_top
